/* File: trsf_fifo.sv */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module trsf_fifo (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sample_valid,
  input  wire trsf_pkg::trsf_set_t     sample_data,
  input  wire logic                    motion_trigger,
  output logic                         ready_irq_pin,
  output logic                         irq
);

  typedef struct packed {
    logic [7:0]          ctrl;
    logic [2:0]          route;
    logic [2:0]          mask;
    logic [2:0]          sticky;
    logic [5:0]          level;
    logic [4:0]          wptr;
    logic [4:0]          rptr;
    logic                trig;
    logic                trig_s1;
    logic                trig_s2;
    logic                trig_prev;
    trsf_pkg::trsf_set_t out_set;
    logic                pop_pend;
    logic [1:0]          burst_idx;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                pin;
    logic                irq;
  } trsf_state_t;

  trsf_state_t         s_q;
  trsf_state_t         s_d;
  trsf_pkg::trsf_set_t mem_rdata;
  logic                mem_we;

  trsf_pkg::trsf_mode_t mode;
  trsf_pkg::trsf_mode_t eff_mode;
  logic [4:0]           wtm;
  logic                 ev_wtm;
  logic                 ev_empty;
  logic                 ev_full;
  logic [2:0]           events;
  logic                 acc_rd;
  logic                 acc_wr;
  logic                 acc_wt;
  logic                 pop;
  logic                 push;
  logic                 drop;
  logic [trsf_pkg::DW-1:0] burst_word;

  // ----------------------------------------------------------------------
  // Sample storage
  // ----------------------------------------------------------------------
  trsf_mem u_mem (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (s_q.wptr),
    .wdata (sample_data),
    .raddr (s_q.rptr),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Mode decode and events
  // ----------------------------------------------------------------------
  always_comb begin
    mode = trsf_pkg::trsf_mode_t'(s_q.ctrl[trsf_pkg::MODE_MSB:trsf_pkg::MODE_LSB]);
    wtm  = s_q.ctrl[trsf_pkg::WTM_MSB:trsf_pkg::WTM_LSB];
    case (mode)
      trsf_pkg::MODE_BYP2STR: begin
        eff_mode = s_q.trig ? trsf_pkg::MODE_STREAM : trsf_pkg::MODE_BYPASS;
      end
      trsf_pkg::MODE_STR2FIFO: begin
        eff_mode = s_q.trig ? trsf_pkg::MODE_FIFO : trsf_pkg::MODE_STREAM;
      end
      trsf_pkg::MODE_FIFO, trsf_pkg::MODE_STREAM: begin
        eff_mode = mode;
      end
      default: begin
        eff_mode = trsf_pkg::MODE_BYPASS;
      end
    endcase
    ev_empty = (s_q.level == 6'h00);
    ev_full  = (s_q.level == trsf_pkg::LVL_MAX);
    ev_wtm   = (eff_mode != trsf_pkg::MODE_BYPASS)
               && (s_q.level >= {1'b0, wtm});
    events   = '0;
    events[trsf_pkg::EV_WTM]   = ev_wtm;
    events[trsf_pkg::EV_EMPTY] = ev_empty;
    events[trsf_pkg::EV_FULL]  = ev_full;
  end

  // ----------------------------------------------------------------------
  // Bus decode and queue moves
  // ----------------------------------------------------------------------
  always_comb begin
    acc_rd = psel && penable && !pwrite && s_q.pready;
    acc_wr = psel && penable && pwrite && s_q.pready;
    acc_wt = psel && penable && !s_q.pready;
    pop = acc_rd && (eff_mode != trsf_pkg::MODE_BYPASS) && !ev_empty
          && ((paddr == trsf_pkg::ADDR_OUT_XY)
              || (paddr == trsf_pkg::ADDR_BURST && s_q.burst_idx == 2'h0));
    push = sample_valid && (eff_mode != trsf_pkg::MODE_BYPASS)
           && !(eff_mode == trsf_pkg::MODE_FIFO && ev_full);
    drop = push && ev_full;
    mem_we = push;
    case (s_q.burst_idx)
      2'h0:    burst_word = s_q.out_set.yaw;
      2'h1:    burst_word = s_q.out_set.pitch;
      default: burst_word = s_q.out_set.roll;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pslverr = 1'b0;
    // Two flop sync of the motion trigger
    s_d.trig_s1   = motion_trigger;
    s_d.trig_s2   = s_q.trig_s1;
    s_d.trig_prev = s_q.trig_s2;

    // Fill level and pointers
    if (push) begin
      s_d.wptr = s_q.wptr + 5'h01;
    end
    if (pop || drop) begin
      s_d.rptr = s_q.rptr + 5'h01;
    end
    if (push && !drop && !pop) begin
      s_d.level = s_q.level + 6'h01;
    end else if (pop && !push) begin
      s_d.level = s_q.level - 6'h01;
    end
    // Bypass holds the queue empty: level, wptr and rptr are forced to zero
    if (eff_mode == trsf_pkg::MODE_BYPASS) begin
      s_d.level = 6'h00;
      s_d.wptr  = 5'h00;
      s_d.rptr  = 5'h00;
    end

    // Registered read data reaches out_set two cycles after the pop
    s_d.pop_pend = pop;
    if (s_q.pop_pend) begin
      s_d.out_set = mem_rdata;
    end else if (eff_mode == trsf_pkg::MODE_BYPASS && sample_valid) begin
      s_d.out_set = sample_data;
    end

    // Sticky status, set beats clear-on-read
    if (acc_rd && paddr == trsf_pkg::ADDR_STATUS) begin
      s_d.sticky = events;
    end else begin
      s_d.sticky = s_q.sticky | events;
    end

    // APB answer: one wait cycle so registered read data can land
    s_d.pready = !(psel && !penable);
    s_d.prdata = 32'h0000_0000;
    if (acc_wt && pwrite) begin
      case (paddr)
        trsf_pkg::ADDR_CTRL, trsf_pkg::ADDR_ROUTE, trsf_pkg::ADDR_MASK: s_d.pslverr = 1'b0;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (acc_wt && !pwrite) begin
      case (paddr)
        trsf_pkg::ADDR_CTRL:   s_d.prdata = {24'h00_0000, s_q.ctrl};
        trsf_pkg::ADDR_ROUTE:  s_d.prdata = {29'h0, s_q.route};
        trsf_pkg::ADDR_MASK:   s_d.prdata = {29'h0, s_q.mask};
        trsf_pkg::ADDR_STATUS: begin
          s_d.prdata = {18'h0, s_q.level, 5'h0, s_q.sticky | events};
        end
        trsf_pkg::ADDR_OUT_XY: s_d.prdata = {s_q.out_set.pitch, s_q.out_set.yaw};
        trsf_pkg::ADDR_OUT_Z:  s_d.prdata = {16'h0000, s_q.out_set.roll};
        trsf_pkg::ADDR_BURST:  s_d.prdata = {16'h0000, burst_word};
        default:               s_d.pslverr = 1'b1;
      endcase
    end
    if (acc_wr) begin
      case (paddr)
        trsf_pkg::ADDR_CTRL: begin
          s_d.ctrl = pwdata[7:0];
          s_d.trig = 1'b0;
          if (pwdata[trsf_pkg::MODE_MSB:trsf_pkg::MODE_LSB] == trsf_pkg::MODE_BYPASS) begin
            s_d.level = 6'h00;
            s_d.wptr  = 5'h00;
            s_d.rptr  = 5'h00;
          end
        end
        trsf_pkg::ADDR_ROUTE: s_d.route = pwdata[2:0];
        trsf_pkg::ADDR_MASK:  s_d.mask  = pwdata[2:0];
        default: begin
        end
      endcase
    end
    if (acc_rd && paddr == trsf_pkg::ADDR_BURST) begin
      s_d.burst_idx = (s_q.burst_idx == trsf_pkg::BURST_LAST)
                      ? 2'h0 : s_q.burst_idx + 2'h1;
    end
    // Trigger arm after the control write, so a coincident edge wins
    if (s_q.trig_s2 && !s_q.trig_prev
        && (mode == trsf_pkg::MODE_BYP2STR || mode == trsf_pkg::MODE_STR2FIFO)) begin
      s_d.trig = 1'b1;
    end

    // Interrupt outputs
    s_d.pin = |(s_d.sticky & s_d.route) | |(events & s_q.route);
    s_d.irq = |(s_d.sticky & s_q.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.ctrl   <= trsf_pkg::CTRL_RST;
      s_q.route  <= trsf_pkg::ROUTE_RST;
      s_q.mask   <= trsf_pkg::MASK_RST;
      s_q.pready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.prdata;
  assign pready        = s_q.pready;
  assign pslverr       = s_q.pslverr;
  assign ready_irq_pin = s_q.pin;
  assign irq           = s_q.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_level_bound: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.level <= trsf_pkg::LVL_MAX) else $error("fill level above 32");
  a_fifo_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_mode == trsf_pkg::MODE_FIFO && ev_full && sample_valid && !acc_wr)
      |=> $stable(s_q.wptr))
    else $error("fifo accepted sample when full");
  a_bypass_empty: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_mode == trsf_pkg::MODE_BYPASS)
      |=> (s_q.level == 6'h00 || eff_mode != trsf_pkg::MODE_BYPASS))
    else $error("bypass not empty");
  a_stream_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_mode == trsf_pkg::MODE_STREAM && ev_full && sample_valid && !pop && !acc_wr)
      |=> ev_full)
    else $error("stream lost full level");
  a_push_grow: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !pop && !drop && !(acc_wr && paddr == trsf_pkg::ADDR_CTRL))
      |=> s_q.level == $past(s_q.level) + 6'h01) else $error("level did not grow");
  a_pop_shrink: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && !push && !(acc_wr)) |=> s_q.level == $past(s_q.level) - 6'h01)
    else $error("level did not shrink");
  a_burst_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_rd && paddr == trsf_pkg::ADDR_BURST && s_q.burst_idx == trsf_pkg::BURST_LAST)
      |=> s_q.burst_idx == 2'h0) else $error("burst did not wrap");
  a_route_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.route == 3'h0 && s_q.sticky == 3'h0 && events == 3'h0) |=> !ready_irq_pin)
    else $error("pin raised without routing");
  a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    ev_full |=> s_q.sticky[trsf_pkg::EV_FULL]) else $error("full not recorded");
  a_bypass_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_wr && paddr == trsf_pkg::ADDR_CTRL
     && pwdata[trsf_pkg::MODE_MSB:trsf_pkg::MODE_LSB] == trsf_pkg::MODE_BYPASS)
      |=> s_q.level == 6'h00) else $error("bypass did not clear");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> !pready) else $error("no wait state after setup");

  c_fifo_full:   cover property (@(posedge pclk) disable iff (!presetn)
    eff_mode == trsf_pkg::MODE_FIFO && ev_full);
  c_stream_drop: cover property (@(posedge pclk) disable iff (!presetn) drop);
  c_trigger:     cover property (@(posedge pclk) disable iff (!presetn) s_q.trig);
  c_burst_wrap:  cover property (@(posedge pclk) disable iff (!presetn)
    acc_rd && paddr == trsf_pkg::ADDR_BURST && s_q.burst_idx == trsf_pkg::BURST_LAST);

endmodule // trsf_fifo

/* File: trsf_pkg.sv */
package trsf_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DEPTH   = 32;
  localparam int unsigned AW      = 5;
  localparam int unsigned DW      = 16;
  localparam int unsigned SETW    = 48;
  localparam logic [5:0]  LVL_MAX = 6'h20;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ROUTE  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_OUT_XY = 8'h10;
  localparam logic [7:0] ADDR_OUT_Z  = 8'h14;
  localparam logic [7:0] ADDR_BURST  = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned WTM_LSB  = 0;
  localparam int unsigned WTM_MSB  = 4;
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned MODE_MSB = 7;
  localparam int unsigned EV_WTM   = 0;
  localparam int unsigned EV_EMPTY = 1;
  localparam int unsigned EV_FULL  = 2;
  localparam int unsigned ST_LVL_LSB = 8;
  localparam int unsigned ST_LVL_MSB = 13;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [2:0] ROUTE_RST = 3'h0;
  localparam logic [2:0] MASK_RST  = 3'h0;
  localparam logic [1:0] BURST_LAST = 2'h2;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_BYPASS    = 3'b000,
    MODE_FIFO      = 3'b001,
    MODE_STREAM    = 3'b010,
    MODE_STR2FIFO  = 3'b011,
    MODE_BYP2STR   = 3'b100
  } trsf_mode_t;

  typedef struct packed {
    logic [DW-1:0] yaw;
    logic [DW-1:0] pitch;
    logic [DW-1:0] roll;
  } trsf_set_t;

endpackage

/* File: trsf_mem.sv */
`timescale 1ns/100ps
module trsf_mem (
  input  wire logic                           clk,
  input  wire logic                           we,
  input  wire logic [trsf_pkg::AW-1:0]        waddr,
  input  wire trsf_pkg::trsf_set_t            wdata,
  input  wire logic [trsf_pkg::AW-1:0]        raddr,
  output trsf_pkg::trsf_set_t                 rdata
);

  // ----------------------------------------------------------------------
  // Sample set storage, registered read
  // ----------------------------------------------------------------------
  trsf_pkg::trsf_set_t mem [trsf_pkg::DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // trsf_mem

/* File: tb_trsf_fifo.sv */
`timescale 1ns/100ps
module tb_trsf_fifo;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                sample_valid;
  trsf_pkg::trsf_set_t sample_data;
  logic                motion_trigger;
  logic                ready_irq_pin;
  logic                irq;
  logic [31:0]         rd;
  logic                er;
  int                  miscompares;
  int                  checks;

  trsf_fifo u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .motion_trigger(motion_trigger), .ready_irq_pin(ready_irq_pin), .irq(irq)
  );

  always #25 pclk = ~pclk;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] msk,
                     input logic [31:0] exp, input string m);
    checks++;
    if ((got & msk) !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got & msk, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] %0t apb ready timeout", $time);
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic trsf_pkg::trsf_set_t mk(input int k);
    return {16'h1000 + k[15:0], 16'h2000 + k[15:0], 16'h3000 + k[15:0]};
  endfunction

  task automatic push(input int n, input int base);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      sample_valid <= 1'b1; sample_data <= mk(base + k);
    end
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask

  task automatic setmode(input logic [2:0] mode, input logic [4:0] wtm);
    apb(1'b1, trsf_pkg::ADDR_CTRL, {24'h0, mode, wtm});
  endtask

  task automatic status(input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, trsf_pkg::ADDR_STATUS, 32'h0);
    chk(rd, msk, exp, "status");
  endtask

  task automatic pop_roll(input int k);
    apb(1'b0, trsf_pkg::ADDR_OUT_XY, 32'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, trsf_pkg::ADDR_OUT_Z, 32'h0);
    chk(rd, 32'hffffffff, {16'h0, 16'h3000 + k[15:0]}, "oldest roll");
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, trsf_pkg::ADDR_CTRL, 32'h0);  chk(rd, 32'hff, 32'h0, "ctrl rst");
    apb(1'b0, trsf_pkg::ADDR_ROUTE, 32'h0); chk(rd, 32'h7, 32'h0, "route rst");
    apb(1'b0, trsf_pkg::ADDR_MASK, 32'h0);  chk(rd, 32'h7, 32'h0, "mask rst");
    status(32'h3f02, 32'h0002);
    apb(1'b1, trsf_pkg::ADDR_CTRL, 32'h2a);
    apb(1'b0, trsf_pkg::ADDR_CTRL, 32'h0);  chk(rd, 32'hff, 32'h2a, "ctrl rw");
    chk({31'h0, er}, 32'h1, 32'h0, "mapped no err");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1, 32'h1, "unmapped err");
    chk(rd, 32'hffffffff, 32'h0, "unmapped data");
    apb(1'b1, 8'h1c, 32'h5);
    chk({31'h0, er}, 32'h1, 32'h1, "unmapped wr err");
    $display("test reset done");
  endtask

  task automatic t_bypass();
    setmode(trsf_pkg::MODE_BYPASS, 5'h0);
    push(5, 0);
    status(32'h3f02, 32'h0002);
    pop_roll(4);
    apb(1'b1, trsf_pkg::ADDR_ROUTE, 32'h2);
    repeat (3) @(posedge pclk);
    chk({31'h0, ready_irq_pin}, 32'h1, 32'h1, "empty routed");
    apb(1'b1, trsf_pkg::ADDR_ROUTE, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, ready_irq_pin}, 32'h1, 32'h0, "empty unrouted");
    $display("test bypass done");
  endtask

  task automatic t_fifo();
    setmode(trsf_pkg::MODE_FIFO, 5'h04);
    apb(1'b1, trsf_pkg::ADDR_ROUTE, 32'h1);
    push(3, 0);
    repeat (3) @(posedge pclk);
    chk({31'h0, ready_irq_pin}, 32'h1, 32'h0, "below wtm");
    push(1, 3);
    repeat (3) @(posedge pclk);
    chk({31'h0, ready_irq_pin}, 32'h1, 32'h1, "at wtm");
    push(30, 4);
    status(32'h3f05, 32'h2005);
    chk({31'h0, irq}, 32'h1, 32'h0, "irq masked");
    apb(1'b1, trsf_pkg::ADDR_MASK, 32'h4);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, 32'h1, "irq unmasked");
    apb(1'b1, trsf_pkg::ADDR_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, 32'h0, "irq remasked");
    pop_roll(0);
    setmode(trsf_pkg::MODE_BYPASS, 5'h0);
    status(32'h3f00, 32'h0);
    $display("test fifo done");
  endtask

  task automatic t_stream();
    setmode(trsf_pkg::MODE_STREAM, 5'h1f);
    push(34, 64);
    status(32'h3f00, 32'h2000);
    repeat (2) @(posedge pclk);
    chk({31'h0, ready_irq_pin}, 32'h1, 32'h1, "stream wtm");
    pop_roll(66);
    apb(1'b0, trsf_pkg::ADDR_BURST, 32'h0); chk(rd, 32'hffff, 32'h1042, "burst yaw");
    repeat (3) @(posedge pclk);
    apb(1'b0, trsf_pkg::ADDR_BURST, 32'h0); chk(rd, 32'hffff, 32'h2043, "burst pitch");
    apb(1'b0, trsf_pkg::ADDR_BURST, 32'h0); chk(rd, 32'hffff, 32'h3043, "burst roll");
    apb(1'b0, trsf_pkg::ADDR_BURST, 32'h0); chk(rd, 32'hffff, 32'h1043, "burst wrap");
    status(32'h3f00, 32'h1d00);
    apb(1'b1, trsf_pkg::ADDR_ROUTE, 32'h0);
    $display("test stream done");
  endtask

  task automatic t_trig();
    setmode(trsf_pkg::MODE_BYPASS, 5'h0);
    setmode(trsf_pkg::MODE_BYP2STR, 5'h0);
    push(3, 0);
    status(32'h3f00, 32'h0);
    motion_trigger <= 1'b1;
    repeat (4) @(posedge pclk);
    push(3, 0);
    status(32'h3f00, 32'h0300);
    motion_trigger <= 1'b0;
    setmode(trsf_pkg::MODE_BYPASS, 5'h0);
    setmode(trsf_pkg::MODE_STR2FIFO, 5'h0);
    push(34, 100);
    motion_trigger <= 1'b1;
    repeat (4) @(posedge pclk);
    push(3, 200);
    status(32'h3f00, 32'h2000);
    pop_roll(102);
    motion_trigger <= 1'b0;
    $display("test trigger done");
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sample_valid = 1'b0; sample_data = '0;
    motion_trigger = 1'b0; miscompares = 0; checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bypass();
    t_fifo();
    t_stream();
    t_trig();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule // tb_trsf_fifo
